/* hdl/scs_glitch_filter.sv */
`timescale 1ns/10ps
module scs_glitch_filter import scs_pkg::*; #(
	parameter int unsigned LIMIT = GLITCH_CYC
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic rawOn,
	output logic      filtOn
);
	localparam int CW = $clog2(LIMIT + 1);

	typedef struct packed {
		logic          on;
		logic [CW-1:0] cnt;
	} scs_filt_t;

	scs_filt_t r_ff;
	scs_filt_t nxt_r;

	// ON is taken at once; OFF only after it outlasts LIMIT cycles
	always_comb begin
		nxt_r = r_ff;
		if (rawOn) begin
			nxt_r.on  = 1'b1;
			nxt_r.cnt = '0;
		end else if (r_ff.cnt == CW'(LIMIT)) begin
			nxt_r.on = 1'b0;
		end else begin
			nxt_r.cnt = r_ff.cnt + CW'(1);
		end
	end

	// Starts as OFF so the drive powers up in cutoff
	always_ff @(posedge clk) begin
		if (reset) begin
			r_ff.on  <= 1'b0;
			r_ff.cnt <= CW'(LIMIT);
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign filtOn = r_ff.on;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	chk_short_off_kept: assert property (
		(!rawOn && r_ff.cnt < CW'(LIMIT) && r_ff.on) |=> filtOn)
		else $error("Short OFF pulse was recognised");
	chk_off_taken: assert property (
		(!rawOn && r_ff.cnt == CW'(LIMIT)) |=> !filtOn)
		else $error("Long OFF was not recognised");
endmodule

/* hdl/scs_safety_cutoff_sequencer.sv */
`timescale 1ns/10ps
// Overview of operation
// - Either safety input going OFF puts the drive into cutoff.
// - Each channel alone can block the power stage drive signals.
// - Both inputs OFF removes motor power within 8 ms.
// - OFF pulses of 0.5 ms or less are ignored.
// - Channels disagreeing longer than 10 s raise the input-skew alarm.
// - Cutoff with enable 0 returns to base block when both inputs ON.
// - Enable 1 seen during cutoff keeps cutoff until enable 0 arrives.
// - Without main circuit power, cutoff holds until enable 0 arrives.
// - Enable 1 is ignored in cutoff and ready stays 0.
// - Ready is 1 only in base block with both inputs ON.
// - Cutoff drops brake release at once, skipping the brake delay.
// - Cutoff stops the motor with the configured disable stop method.
// - Cutoff ends a local function; restoring inputs does not restart it.
// - Both safety input states are visible on monitor outputs.
// - Failure monitor is ON only with both inputs OFF, within 8 ms.
// - General alarm output is suppressed during cutoff.
module scs_safety_cutoff_sequencer import scs_pkg::*; #(
	parameter int unsigned GLITCH_LIM = GLITCH_CYC,
	parameter int unsigned SKEW_LIM   = SKEW_CYC,
	parameter int unsigned RESP_LIM   = RESP_CYC
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             safetyInputA,
	input  wire logic             safetyInputB,
	input  wire logic             enableCmd,
	input  wire logic             mainPowerOn,
	input  wire logic [BRK_W-1:0] brakeToDisableDelay,
	input  wire logic [1:0]       stopMethodSetting,
	input  wire logic             localFuncEnter,
	input  wire logic             localFuncExit,
	input  wire logic             alarmIn,
	output logic                  gateEnableA,
	output logic                  gateEnableB,
	output logic                  cutoffState,
	output logic                  readyStatus,
	output logic                  inputSkewAlarm,
	output logic                  brakeReleaseOutput,
	output logic                  stopRequest,
	output logic [1:0]            stopMode,
	output logic                  failureMonitorOutput,
	output logic                  generalAlarmOutput,
	output logic                  monitorInputA,
	output logic                  monitorInputB,
	output logic                  localFuncRun
);
	typedef struct packed {
		scs_state_t       st;
		logic             enInCut;
		logic [31:0]      skewCnt;
		logic             skewAlarm;
		logic [BRK_W-1:0] brkCnt;
		logic             brake;
		logic             gateA;
		logic             gateB;
		logic             cut;
		logic             ready;
		logic             stopReq;
		logic [1:0]       stopMode;
		logic             failMon;
		logic             genAlarm;
		logic             monA;
		logic             monB;
		logic             funcRun;
		logic             enterPrev;
	} scs_regs_t;

	scs_regs_t r_ff;
	scs_regs_t nxt_r;
	logic      filtA;
	logic      filtB;

	function automatic logic isCut(input scs_state_t s);
		return (s == ST_CUT) || (s == ST_CUTWAIT);
	endfunction

	// One filter per channel keeps the two paths independent
	scs_glitch_filter #(.LIMIT(GLITCH_LIM)) u_filtA (
		.clk    (clk),
		.reset  (reset),
		.rawOn  (safetyInputA),
		.filtOn (filtA)
	);
	scs_glitch_filter #(.LIMIT(GLITCH_LIM)) u_filtB (
		.clk    (clk),
		.reset  (reset),
		.rawOn  (safetyInputB),
		.filtOn (filtB)
	);

	always_comb begin
		logic req;
		req   = !filtA || !filtB;
		nxt_r = r_ff;
		case (r_ff.st)
			ST_BASE: begin
				if (req) nxt_r.st = ST_CUT;
				else if (enableCmd) nxt_r.st = ST_RUN;
			end
			ST_RUN: begin
				if (req) nxt_r.st = ST_CUT;
				else if (!enableCmd) nxt_r.st = ST_BASE;
			end
			ST_CUT: begin
				// Enable never starts the drive here; an enable of 1 only sends the exit through ST_CUTWAIT
				if (!req) begin
					if (r_ff.enInCut || enableCmd || !mainPowerOn) begin
						nxt_r.st = ST_CUTWAIT;
					end else begin
						nxt_r.st = ST_BASE;
					end
				end
			end
			ST_CUTWAIT: begin
				if (req) nxt_r.st = ST_CUT;
				else if (!enableCmd) nxt_r.st = ST_BASE;
			end
			default: nxt_r.st = ST_CUT;
		endcase
		// Remembers an enable of 1 seen while the inputs were OFF
		nxt_r.enInCut = (r_ff.st == ST_CUT && nxt_r.st == ST_CUT)
			? (r_ff.enInCut || enableCmd) : 1'b0;

		nxt_r.cut   = isCut(nxt_r.st);
		nxt_r.gateA = filtA && nxt_r.st == ST_RUN;
		nxt_r.gateB = filtB && nxt_r.st == ST_RUN;
		nxt_r.ready = nxt_r.st == ST_BASE;

		// Brake release: immediate drop in cutoff, delayed after normal disable
		if (nxt_r.st == ST_RUN) begin
			nxt_r.brake  = 1'b1;
			nxt_r.brkCnt = brakeToDisableDelay;
		end else if (nxt_r.cut) begin
			nxt_r.brake  = 1'b0;
			nxt_r.brkCnt = '0;
		end else if (r_ff.brkCnt != '0) begin
			nxt_r.brkCnt = r_ff.brkCnt - BRK_W'(1);
		end else begin
			nxt_r.brake = 1'b0;
		end

		// Same stop method for cutoff as for a normal disable
		nxt_r.stopReq = (!isCut(r_ff.st) && nxt_r.cut)
			|| (r_ff.st == ST_RUN && nxt_r.st == ST_BASE);
		if (nxt_r.stopReq) nxt_r.stopMode = stopMethodSetting;

		// Skew alarm is latched; only reset clears it, so a flaky wire is seen
		if (filtA != filtB) begin
			if (r_ff.skewCnt >= SKEW_LIM) nxt_r.skewAlarm = 1'b1;
			else nxt_r.skewCnt = r_ff.skewCnt + 32'h0000_0001;
		end else begin
			nxt_r.skewCnt = '0;
		end

		nxt_r.failMon  = !filtA && !filtB;
		nxt_r.genAlarm = alarmIn && !nxt_r.cut;
		nxt_r.monA     = filtA;
		nxt_r.monB     = filtB;

		// Entry counts on its rising edge only, so a held entry cannot restart after cutoff
		nxt_r.enterPrev = localFuncEnter;
		if (nxt_r.cut || localFuncExit) nxt_r.funcRun = 1'b0;
		else if (localFuncEnter && !r_ff.enterPrev) nxt_r.funcRun = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r_ff          <= '0;
			r_ff.st       <= ST_CUT;
			r_ff.cut      <= 1'b1;
			r_ff.stopMode <= STOP_MODE_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign gateEnableA          = r_ff.gateA;
	assign gateEnableB          = r_ff.gateB;
	assign cutoffState          = r_ff.cut;
	assign readyStatus          = r_ff.ready;
	assign inputSkewAlarm       = r_ff.skewAlarm;
	assign brakeReleaseOutput   = r_ff.brake;
	assign stopRequest          = r_ff.stopReq;
	assign stopMode             = r_ff.stopMode;
	assign failureMonitorOutput = r_ff.failMon;
	assign generalAlarmOutput   = r_ff.genAlarm;
	assign monitorInputA        = r_ff.monA;
	assign monitorInputB        = r_ff.monB;
	assign localFuncRun         = r_ff.funcRun;

	// Helper: cycles with both raw inputs OFF
	logic [31:0] offCnt;
	always_ff @(posedge clk) begin
		if (reset || safetyInputA || safetyInputB) offCnt <= '0;
		else if (offCnt != 32'hFFFF_FFFF) offCnt <= offCnt + 32'h0000_0001;
	end

	// Helper: cycles with the filtered channels disagreeing
	logic [31:0] skewSeen;
	always_ff @(posedge clk) begin
		if (reset || filtA == filtB) skewSeen <= '0;
		else if (skewSeen != 32'hFFFF_FFFF) skewSeen <= skewSeen + 32'h0000_0001;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	chk_cutoff_entry: assert property ((!filtA || !filtB) |=> cutoffState)
		else $error("Cutoff not entered on an OFF input");
	chk_gate_chan: assert property ((!filtA |=> !gateEnableA) and (!filtB |=> !gateEnableB))
		else $error("One channel failed to block its gate");
	chk_resp_time: assert property ((offCnt >= RESP_LIM) |-> !gateEnableA && !gateEnableB)
		else $error("Motor power not removed in time");
	chk_skew_alarm: assert property (($rose(inputSkewAlarm) |-> skewSeen > SKEW_LIM)
		and ((skewSeen > SKEW_LIM) |-> inputSkewAlarm))
		else $error("Skew alarm not raised at the skew limit");
	chk_bb_return: assert property ((r_ff.st == ST_CUT && filtA && filtB && !enableCmd
		&& !r_ff.enInCut && mainPowerOn) |=> readyStatus)
		else $error("Base block not reached after inputs ON");
	chk_enable_hold: assert property ((r_ff.st == ST_CUT && enableCmd) |=> cutoffState)
		else $error("Enable during cutoff left cutoff");
	chk_no_main_power: assert property ((r_ff.st == ST_CUT && !mainPowerOn) |=> !readyStatus)
		else $error("Base block without main power");
	chk_ready_cut: assert property (cutoffState |-> !readyStatus)
		else $error("Ready set in cutoff");
	chk_ready_cond: assert property (readyStatus |-> monitorInputA && monitorInputB && !gateEnableA)
		else $error("Ready without both inputs ON and drive off");
	chk_brake_drop: assert property ($rose(cutoffState) |-> !brakeReleaseOutput)
		else $error("Brake release held on cutoff entry");
	chk_stop_mode: assert property ($rose(cutoffState) && !$past(reset) |-> stopRequest
		&& stopMode == $past(stopMethodSetting))
		else $error("Cutoff stop method wrong");
	chk_func_kill: assert property (($rose(cutoffState) |-> !localFuncRun)
		and ($rose(localFuncRun) |-> !cutoffState && $past(localFuncEnter)
		&& !$past(localFuncEnter, 2)))
		else $error("Local function runs without a fresh entry");
	chk_fail_mon: assert property (failureMonitorOutput |-> $past(!filtA && !filtB))
		else $error("Failure monitor ON with an input ON");
	chk_alarm_mask: assert property (cutoffState |-> !generalAlarmOutput)
		else $error("General alarm in cutoff");

	cov_cutoff: cover property ($rose(cutoffState));
	cov_wait: cover property (r_ff.st == ST_CUTWAIT ##1 r_ff.st == ST_BASE);
	cov_skew: cover property ($rose(inputSkewAlarm));
	cov_run: cover property (r_ff.st == ST_RUN ##1 r_ff.st == ST_BASE);
endmodule

/* pkg/scs_pkg.sv */
package scs_pkg;
	// Control clock rate
	localparam int CLK_HZ     = 50_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1_000;
	// OFF pulses this long or shorter are ignored
	localparam int GLITCH_US  = 500;
	localparam int GLITCH_CYC = GLITCH_US * CYC_PER_US;
	// Longest time from both inputs OFF to motor current removed
	localparam int RESP_MS    = 8;
	localparam int RESP_CYC   = RESP_MS * CYC_PER_MS;
	// Allowed disagreement between the two safety channels
	localparam int SKEW_MS    = 10_000;
	localparam int SKEW_CYC   = SKEW_MS * CYC_PER_MS;
	// Width in bits of the brake-to-disable delay setting, which counts cycles
	localparam int BRK_W      = 16;
	localparam logic [1:0] STOP_MODE_RST = 2'h0;

	typedef enum logic [1:0] {
		ST_BASE    = 2'b00,
		ST_RUN     = 2'b01,
		ST_CUT     = 2'b11,
		ST_CUTWAIT = 2'b10
	} scs_state_t;
endpackage

/* test/scs_safety_cutoff_sequencer_tb.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin nErrors++; \
	$display("wrong value at %0t: got %b expected %b", $time, g, e); end end
module scs_safety_cutoff_sequencer_tb;
	import scs_pkg::*;
	localparam int GL = 8;
	typedef struct packed {
		logic [4:0] stim;
		logic [5:0] exp;
	} scs_row_t;
	logic             clk = 1'b0;
	logic             reset = 1'b1;
	logic             onA = 1'b1, onB = 1'b1, hostEn = 1'b0;
	logic             mainPowerOn = 1'b1, alarmIn = 1'b1;
	logic             fEnter = 1'b0, fExit = 1'b0;
	logic             monOk;
	logic [BRK_W-1:0] brkDly = 16'h0004;
	logic [1:0]       stopSet = 2'h0;
	logic             sA, sB, en;
	logic             gA, gB, cut, rdy, skew, brk, stopReq, fm, gAlm, monA, monB, lfRun;
	logic [1:0]       stopMode;
	int               nErrors = 0, checksDone = 0;
	// Columns: {a, b, en, power, alarm} -> {cut, ready, gate, fm, alarm out, monA}
	scs_row_t rows [9] = '{
		'{5'b11011, 6'b010011}, '{5'b11111, 6'b001011}, '{5'b11011, 6'b010011},
		'{5'b00011, 6'b100100}, '{5'b00111, 6'b100100}, '{5'b11111, 6'b100001},
		'{5'b11011, 6'b010011}, '{5'b01011, 6'b100000}, '{5'b11011, 6'b010011}};
	always #10 clk = ~clk;
	scs_safety_unit PARTNER (.onA(onA), .onB(onB), .hostEn(hostEn), .failMon(fm),
		.safetyInputA(sA), .safetyInputB(sB), .enableCmd(en), .monitorOk(monOk));
	scs_safety_cutoff_sequencer #(.GLITCH_LIM(GL), .SKEW_LIM(40), .RESP_LIM(GL + 4)) DUT (
		.clk(clk), .reset(reset), .safetyInputA(sA), .safetyInputB(sB), .enableCmd(en),
		.mainPowerOn(mainPowerOn), .brakeToDisableDelay(brkDly),
		.stopMethodSetting(stopSet), .localFuncEnter(fEnter), .localFuncExit(fExit),
		.alarmIn(alarmIn), .gateEnableA(gA), .gateEnableB(gB), .cutoffState(cut),
		.readyStatus(rdy), .inputSkewAlarm(skew), .brakeReleaseOutput(brk),
		.stopRequest(stopReq), .stopMode(stopMode), .failureMonitorOutput(fm),
		.generalAlarmOutput(gAlm), .monitorInputA(monA), .monitorInputB(monB),
		.localFuncRun(lfRun));
	task automatic results();
		$display("checks %0d errors %0d", checksDone, nErrors);
		if (nErrors == 0 && checksDone > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	// Whole run is near 290 cycles, so this leaves a wide margin
	initial begin
		cyc(3000);
		nErrors++;
		results();
	end
	initial begin
		cyc(20);
		`CHK({cut, rdy, gA, fm, skew}, 5'b10000)
		reset = 1'b0;
		foreach (rows[i]) begin
			{onA, onB, hostEn, mainPowerOn, alarmIn} = rows[i].stim;
			cyc(GL + 6);
			`CHK({cut, rdy, gA, fm, gAlm, monA}, rows[i].exp)
			`CHK({gB, monB}, {rows[i].exp[3], onB})
			`CHK(monOk, 1'b1)
			$display("row %0d done", i);
		end
		// Run with a long brake delay and a local function going
		brkDly = 16'h00FF;
		stopSet = 2'h2;
		hostEn = 1'b1;
		cyc(4);
		fEnter = 1'b1;
		cyc(1);
		fEnter = 1'b0;
		cyc(2);
		`CHK({lfRun, brk, gA}, 3'b111)
		onA = 1'b0;
		cyc(GL);
		onA = 1'b1;
		cyc(6);
		`CHK({cut, gA, gB}, 3'b011)
		$display("glitch test done");
		onA = 1'b0;
		cyc(GL + 1);
		`CHK(cut, 1'b0)
		cyc(1);
		`CHK({cut, gA, gB, brk, stopReq, stopMode}, 7'b1000110)
		`CHK(gAlm, 1'b0)
		fEnter = 1'b1;
		cyc(30);
		`CHK({skew, lfRun, fm}, 3'b000)
		cyc(20);
		`CHK(skew, 1'b1)
		$display("cutoff and skew test done");
		onA = 1'b1;
		cyc(GL);
		`CHK({cut, rdy}, 2'b10)
		hostEn = 1'b0;
		cyc(4);
		`CHK({cut, rdy, lfRun, skew}, 4'b0101)
		fEnter = 1'b0;
		cyc(1);
		fEnter = 1'b1;
		cyc(1);
		`CHK(lfRun, 1'b1)
		fExit = 1'b1;
		cyc(1);
		`CHK(lfRun, 1'b0)
		{fEnter, fExit} = 2'b00;
		$display("restart test done");
		// Both channels OFF while the drive runs
		hostEn = 1'b1;
		cyc(2);
		`CHK(gA, 1'b1)
		{onA, onB} = 2'b00;
		cyc(GL + 4);
		`CHK({gA, gB, fm, cut}, 4'b0011)
		{onA, onB, hostEn} = 3'b110;
		cyc(GL);
		`CHK({cut, rdy}, 2'b01)
		// Inputs return while main power is off
		mainPowerOn = 1'b0;
		{onA, onB} = 2'b00;
		cyc(GL + 4);
		{onA, onB} = 2'b11;
		cyc(2);
		`CHK({cut, rdy}, 2'b10)
		cyc(1);
		`CHK({cut, rdy}, 2'b01)
		mainPowerOn = 1'b1;
		$display("response and power test done");
		// Reset in mid-run clears the latched skew alarm
		reset = 1'b1;
		cyc(3);
		`CHK({cut, rdy, skew, gA, fm}, 5'b10000)
		reset = 1'b0;
		cyc(4);
		`CHK({cut, rdy, skew}, 3'b010)
		$display("reset test done");
		results();
	end
endmodule

/* test/scs_safety_unit.sv */
`timescale 1ns/10ps
// External safety unit and host; levels pass straight through so the
// bench keeps full control of when each channel changes
module scs_safety_unit (
	input  wire logic onA,
	input  wire logic onB,
	input  wire logic hostEn,
	input  wire logic failMon,
	output logic      safetyInputA,
	output logic      safetyInputB,
	output logic      enableCmd,
	output logic      monitorOk
);
	// Host watches the failure monitor: ON only with both channels OFF
	assign monitorOk    = (onA || onB) ? !failMon : failMon;
	assign safetyInputA = onA;
	assign safetyInputB = onB;
	assign enableCmd    = hostEn; // Host sends 0 before a fresh 1 after cutoff
endmodule
